// File: tci_pkg.sv
// Package with register map and field constants for the transmit irq block.
`default_nettype none

package tci_pkg;

   // Geometry of the block.
   localparam int CHAN_N = 8;
   localparam int ADR_W  = 8;
   localparam int DAT_W  = 32;
   localparam int SEL_W  = DAT_W / 8;

   // Byte offsets of the registers on the bus.
   localparam logic [ADR_W-1:0] OFS_RAW     = 8'h00;
   localparam logic [ADR_W-1:0] OFS_MASKED  = 8'h04;
   localparam logic [ADR_W-1:0] OFS_EN_SET  = 8'h08;
   localparam logic [ADR_W-1:0] OFS_EN_CLR  = 8'h0c;
   localparam logic [ADR_W-1:0] OFS_VECTOR  = 8'h10;
   localparam logic [ADR_W-1:0] OFS_EVT_ST  = 8'h14;
   localparam logic [ADR_W-1:0] OFS_EVT_MSK = 8'h18;

   // Field positions and the byte lane index.
   localparam int VEC_TX_LSB = 16;
   localparam int WORD_LSB   = 2;
   localparam int LANE0      = 0;

   // Reset values.
   localparam logic [CHAN_N-1:0] RST_EN      = 8'h00;
   localparam logic [CHAN_N-1:0] RST_EVT     = 8'h00;
   localparam logic [CHAN_N-1:0] RST_EVT_MSK = 8'h00;
   localparam logic [DAT_W-1:0]  RST_DATA    = 32'h0000_0000;

endpackage : tci_pkg

`default_nettype wire

// File: tci_regbus_if.sv
// Interface carrying register requests from the bus slave to the core.
`timescale 1ns/10ps
`default_nettype none

interface tci_regbus_if #(
   parameter int AW = 8,
   parameter int DW = 32
);
   logic            take;    // Request accepted, read data latched.
   logic            wr;      // Write commits in this cycle.
   logic [AW-1:0]   addr;    // Word-aligned byte address.
   logic [DW-1:0]   wdata;   // Write data.
   logic [DW/8-1:0] sel;     // Byte lane selects.
   logic [DW-1:0]   rdata;   // Read data from the core.

   // Bus side drives requests, core side answers with read data.
   modport bus  (output take, wr, addr, wdata, sel, input rdata);
   modport core (input take, wr, addr, wdata, sel, output rdata);
endinterface : tci_regbus_if

`default_nettype wire

// File: tci_sticky.sv
// Bit vector with independent set and clear strobes, set winning.
`timescale 1ns/10ps
`default_nettype none

module tci_sticky #(
   parameter int           W   = 8,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clock,   // Core clock.
   input  wire logic         arst_n,  // Async reset, active low.
   input  wire logic         ce,      // Clock enable.
   input  wire logic [W-1:0] set,     // Bits to set.
   input  wire logic [W-1:0] clr,     // Bits to clear.
   output logic      [W-1:0] q        // Current value.
);
   logic [W-1:0] q_q;
   logic [W-1:0] q_d;

   // A set arriving with a clear is kept, so no event is lost.
   assign q_d = (q_q & ~clr) | set;
   assign q   = q_q;

   // State holds while the clock enable is low.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q_q <= RST;
      end else if (ce) begin
         q_q <= q_d;
      end
   end
endmodule : tci_sticky

`default_nettype wire

// File: tci_wb_slave.sv
// Classic Wishbone slave front end with a registered one-cycle answer.
`timescale 1ns/10ps
`default_nettype none

module tci_wb_slave (
   input  wire logic                       clock,     // Core clock.
   input  wire logic                       arst_n,    // Async reset.
   input  wire logic                       ce,        // Clock enable.
   input  wire logic                       wb_cyc_i,  // Bus cycle.
   input  wire logic                       wb_stb_i,  // Strobe.
   input  wire logic                       wb_we_i,   // Write enable.
   input  wire logic [tci_pkg::ADR_W-1:0]  wb_adr_i,  // Byte address.
   input  wire logic [tci_pkg::SEL_W-1:0]  wb_sel_i,  // Lane selects.
   input  wire logic [tci_pkg::DAT_W-1:0]  wb_dat_i,  // Write data.
   output logic      [tci_pkg::DAT_W-1:0]  wb_dat_o,  // Read data.
   output logic                            wb_ack_o,  // Acknowledge.
   tci_regbus_if.bus                       rb         // Core requests.
);
   logic                      ack_q;
   logic                      ack_d;
   logic [tci_pkg::DAT_W-1:0] dat_q;
   logic [tci_pkg::DAT_W-1:0] dat_d;
   logic                      req;

   // The request is taken while no answer is out; the write lands at the
   // edge where the master sees ack, so it never lands twice.
   assign req      = wb_cyc_i & wb_stb_i;
   assign rb.take  = req & ~ack_q & ce;
   assign rb.wr    = req & wb_we_i & ack_q & ce;
   assign rb.addr  = {wb_adr_i[tci_pkg::ADR_W-1:tci_pkg::WORD_LSB],
                      2'b00};
   assign rb.wdata = wb_dat_i;
   assign rb.sel   = wb_sel_i;
   assign ack_d    = rb.take;
   assign dat_d    = rb.take ? rb.rdata : dat_q;

   // Ack is gated by the enable so a frozen cycle is never acknowledged.
   assign wb_ack_o = ack_q & ce;
   assign wb_dat_o = dat_q;

   // Answer registers.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ack_q <= 1'b0;
         dat_q <= tci_pkg::RST_DATA;
      end else if (ce) begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end
endmodule : tci_wb_slave

`default_nettype wire

// File: tci_tx_irq.sv
// Transmit channel interrupt status, enable and request logic.
//
// Overview of operation
// - Raw view shows each channel's pending bit in bits 7..0, enable ignored.
// - Masked view bit set only when raw pending and enable both set.
// - Writing one to enable-set bit n enables channel n interrupt.
// - Zero bits written to enable-set leave those enables unchanged.
// - Enable-set reads back current enables; reset clears all eight.
// - Bits 31..8 of raw, masked and enable registers read zero.
// - Writing one to enable-clear bit n disables channel n; zero no effect.
// - Masked pending bits also appear in vector bits 23..16, channel 0 at 16.
`timescale 1ns/10ps
`default_nettype none

module tci_tx_irq (
   input  wire logic                       clock,      // 125 MHz clock.
   input  wire logic                       arst_n,     // Async reset.
   input  wire logic                       ce,         // Clock enable.
   input  wire logic                       wb_cyc_i,   // Bus cycle.
   input  wire logic                       wb_stb_i,   // Strobe.
   input  wire logic                       wb_we_i,    // Write enable.
   input  wire logic [tci_pkg::ADR_W-1:0]  wb_adr_i,   // Byte address.
   input  wire logic [tci_pkg::SEL_W-1:0]  wb_sel_i,   // Lane selects.
   input  wire logic [tci_pkg::DAT_W-1:0]  wb_dat_i,   // Write data.
   output logic      [tci_pkg::DAT_W-1:0]  wb_dat_o,   // Read data.
   output logic                            wb_ack_o,   // Acknowledge.
   input  wire logic [tci_pkg::CHAN_N-1:0] tx_pend_i,  // Channel pending.
   output logic                            tx_irq_o,   // Masked request.
   output logic                            irq_o       // Event interrupt.
);
   localparam int N = tci_pkg::CHAN_N;
   localparam int W = tci_pkg::DAT_W;

   tci_regbus_if #(.AW(tci_pkg::ADR_W), .DW(W)) rb ();

   logic [N-1:0] raw_q;
   logic [N-1:0] raw_d;
   logic [N-1:0] en_q;
   logic [N-1:0] masked;
   logic [N-1:0] evt_q;
   logic [N-1:0] evt_rise;
   logic [N-1:0] evt_msk_q;
   logic [N-1:0] evt_msk_d;
   logic [N-1:0] wd;
   logic [N-1:0] en_set;
   logic [N-1:0] en_clr;
   logic [N-1:0] evt_clr;

   // Bus front end.
   tci_wb_slave u_bus (
      .clock    (clock),
      .arst_n   (arst_n),
      .ce       (ce),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .rb       (rb.bus)
   );

   // Address decode.
   logic hit_raw;
   logic hit_masked;
   logic hit_set;
   logic hit_clr;
   logic hit_vec;
   logic hit_evt;
   logic hit_emsk;
   logic lane0;

   assign hit_raw    = rb.addr == tci_pkg::OFS_RAW;
   assign hit_masked = rb.addr == tci_pkg::OFS_MASKED;
   assign hit_set    = rb.addr == tci_pkg::OFS_EN_SET;
   assign hit_clr    = rb.addr == tci_pkg::OFS_EN_CLR;
   assign hit_vec    = rb.addr == tci_pkg::OFS_VECTOR;
   assign hit_evt    = rb.addr == tci_pkg::OFS_EVT_ST;
   assign hit_emsk   = rb.addr == tci_pkg::OFS_EVT_MSK;

   // Only byte lane 0 holds live bits; upper lanes are ignored on write.
   assign lane0 = rb.sel[tci_pkg::LANE0];
   assign wd    = rb.wdata[N-1:0];

   // Write strobes for the one-to-set and one-to-clear ports.
   assign en_set  = (rb.wr & lane0 & hit_set) ? wd : '0;
   assign en_clr  = (rb.wr & lane0 & hit_clr) ? wd : '0;
   assign evt_clr = (rb.wr & lane0 & hit_evt) ? wd : '0;

   // Channel pending inputs are synchronous; they are sampled once so the
   // raw view and the event detector see the same value.
   assign raw_d = tx_pend_i;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         raw_q <= tci_pkg::RST_EVT;
      end else if (ce) begin
         raw_q <= raw_d;
      end
   end

   // Channel enables: set and clear come from different addresses, so
   // they never meet in one cycle.
   tci_sticky #(.W(N), .RST(tci_pkg::RST_EN)) u_enable (
      .clock  (clock),
      .arst_n (arst_n),
      .ce     (ce),
      .set    (en_set),
      .clr    (en_clr),
      .q      (en_q)
   );

   // Masked view and the transmit request built from it.
   assign masked   = raw_q & en_q;
   assign tx_irq_o = |masked;

   // A new pending edge on any channel is kept as a sticky event, so a
   // short pulse on a channel is not missed by slow software.
   assign evt_rise = raw_d & ~raw_q;

   tci_sticky #(.W(N), .RST(tci_pkg::RST_EVT)) u_event (
      .clock  (clock),
      .arst_n (arst_n),
      .ce     (ce),
      .set    (evt_rise),
      .clr    (evt_clr),
      .q      (evt_q)
   );

   // Event mask is a plain read-write register.
   assign evt_msk_d = (rb.wr & lane0 & hit_emsk) ? wd : evt_msk_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         evt_msk_q <= tci_pkg::RST_EVT_MSK;
      end else if (ce) begin
         evt_msk_q <= evt_msk_d;
      end
   end

   // Level interrupt while any unmasked event is held.
   assign irq_o = |(evt_q & evt_msk_q);

   // Read data selection; upper bits are tied to zero and unmapped
   // addresses answer with an all-zero word.
   logic [W-1:0] rd_raw;
   logic [W-1:0] rd_masked;
   logic [W-1:0] rd_en;
   logic [W-1:0] rd_vec;
   logic [W-1:0] rd_evt;
   logic [W-1:0] rd_emsk;

   assign rd_raw    = {{(W-N){1'b0}}, raw_q};
   assign rd_masked = {{(W-N){1'b0}}, masked};
   assign rd_en     = {{(W-N){1'b0}}, en_q};
   assign rd_vec    = {{(W-N-tci_pkg::VEC_TX_LSB){1'b0}}, masked,
                       {tci_pkg::VEC_TX_LSB{1'b0}}};
   assign rd_evt    = {{(W-N){1'b0}}, evt_q};
   assign rd_emsk   = {{(W-N){1'b0}}, evt_msk_q};

   assign rb.rdata = ({W{hit_raw}}           & rd_raw)
                   | ({W{hit_masked}}        & rd_masked)
                   | ({W{hit_set | hit_clr}} & rd_en)
                   | ({W{hit_vec}}           & rd_vec)
                   | ({W{hit_evt}}           & rd_evt)
                   | ({W{hit_emsk}}          & rd_emsk);

   // Checks on the block's own outputs and state.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   // A request taken on a given register.
   sequence s_take(hit);
      rb.take && hit;
   endsequence

   // A write that commits on a given register.
   sequence s_commit(hit);
      rb.wr && lane0 && hit;
   endsequence

   // A taken request answered one enabled edge later.
   sequence s_answer;
      ce && wb_ack_o;
   endsequence

   chk_masked_and_raw: assert property (
      s_take(hit_masked)
      |=> wb_dat_o[N-1:0] == ($past(raw_q) & $past(en_q)))
      else $error("masked view differs from raw and enable");

   chk_raw_follows_pend: assert property (
      ce |=> raw_q == $past(tx_pend_i))
      else $error("raw view does not follow channel pending");

   chk_enable_set_bits: assert property (
      s_commit(hit_set) |=> (en_q & $past(wd)) == $past(wd))
      else $error("enable set write did not set its bits");

   chk_enable_keep_zero: assert property (
      s_commit(hit_set) |=> ((en_q ^ $past(en_q)) & ~$past(wd)) == '0)
      else $error("enable set write changed a zero bit");

   chk_enable_readback: assert property (
      s_take(hit_set) |=> wb_dat_o == {{(W-N){1'b0}}, $past(en_q)})
      else $error("enable readback wrong");

   chk_reserved_zero: assert property (
      s_take(hit_raw || hit_masked || hit_set)
      |=> wb_dat_o[W-1:N] == '0)
      else $error("reserved bits read nonzero");

   chk_enable_clear_bits: assert property (
      s_commit(hit_clr) |=> (en_q & $past(wd)) == '0)
      else $error("enable clear write left a bit set");

   chk_vector_tx_field: assert property (
      s_take(hit_vec) |=> wb_dat_o[tci_pkg::VEC_TX_LSB +: N]
                          == $past(masked))
      else $error("vector field differs from masked view");

   chk_tx_irq_level: assert property (
      ce |=> tx_irq_o == (($past(tx_pend_i) & en_q) != '0))
      else $error("transmit request differs from masked view");

   chk_event_sticky: assert property (
      (ce && evt_rise != '0) |=> (evt_q & $past(evt_rise))
                                 == $past(evt_rise))
      else $error("pending edge not captured as event");

   chk_ack_single: assert property (
      rb.take ##1 s_answer |=> !wb_ack_o)
      else $error("acknowledge held for more than one cycle");

endmodule : tci_tx_irq

`default_nettype wire

// File: tci_tb.sv
// Self-checking testbench for the transmit channel interrupt block.
`timescale 1ns/10ps
`default_nettype none

module tb;
   logic        clock    = 1'b0;
   logic        arst_n   = 1'b0;
   logic        ce       = 1'b1;
   logic        cyc      = 1'b0;
   logic        stb      = 1'b0;
   logic        we       = 1'b0;
   logic [7:0]  adr      = 8'h00;
   logic [3:0]  sel      = 4'h0;
   logic [31:0] wdat     = 32'h0000_0000;
   logic [31:0] rdat;
   logic        ack;
   logic [7:0]  tx_pend  = 8'h00;
   logic        tx_irq;
   logic        irq;
   int          mismatches = 0;
   int          compares   = 0;
   int          cycles     = 0;

   // The clock toggles every half period of 4 ns.
   always #4 clock = ~clock;

   tci_tx_irq tci_tx_irq_i (
      .clock     (clock),
      .arst_n    (arst_n),
      .ce        (ce),
      .wb_cyc_i  (cyc),
      .wb_stb_i  (stb),
      .wb_we_i   (we),
      .wb_adr_i  (adr),
      .wb_sel_i  (sel),
      .wb_dat_i  (wdat),
      .wb_dat_o  (rdat),
      .wb_ack_o  (ack),
      .tx_pend_i (tx_pend),
      .tx_irq_o  (tx_irq),
      .irq_o     (irq)
   );

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   // Cuts a hang short; the whole sequence needs well under this count.
   always @(posedge clock) begin
      cycles++;
      if (cycles >= 5000) begin
         mismatches++;
         finish_test();
      end
   end

   // One classic cycle; holds everything until ack is sampled high.
   task automatic wb_cycle(input logic w, input logic [7:0] a,
                           input logic [31:0] d, input logic [3:0] s,
                           output logic [31:0] q);
      @(posedge clock);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      // Only the bench timeout ends a wait that never sees ack.
      do begin
         @(posedge clock);
      end while (ack !== 1'b1);
      q   = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb_cycle

   task automatic wb_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s = 4'hf);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, s, q);
   endtask : wb_write

   // Compares a 32-bit register value read over the bus.
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input string name);
      logic [31:0] got;
      compares++;
      wb_cycle(1'b0, a, 32'h0000_0000, 4'hf, got);
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : rd_chk

   // Compares an output flag once the last edge's updates have landed.
   task automatic flag_chk(input string name, input logic exp,
                           input logic got_now);
      compares++;
      if (got_now !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got_now);
      end
   endtask : flag_chk

   // Main sequence of register traffic and pending-input changes.
   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd_chk(8'(i * 4), 32'h0000_0000, "reset value");
      end
      tx_pend <= 8'ha5;
      rd_chk(tci_pkg::OFS_RAW, 32'h0000_00a5, "raw");
      rd_chk(tci_pkg::OFS_MASKED, 32'h0000_0000, "masked");
      #1 flag_chk("tx_irq", 1'b0, tx_irq);
      wb_write(tci_pkg::OFS_EN_SET, 32'hffff_ff03);
      rd_chk(tci_pkg::OFS_EN_SET, 32'h0000_0003, "enables");
      rd_chk(tci_pkg::OFS_MASKED, 32'h0000_0001, "masked");
      rd_chk(tci_pkg::OFS_VECTOR, 32'h0001_0000, "vector");
      #1 flag_chk("tx_irq", 1'b1, tx_irq);
      wb_write(tci_pkg::OFS_EN_SET, 32'h0000_0000);
      wb_write(tci_pkg::OFS_EN_SET, 32'h0000_0080, 4'he);
      rd_chk(tci_pkg::OFS_EN_SET, 32'h0000_0003, "enables");
      wb_write(tci_pkg::OFS_EN_SET, 32'h0000_0080);
      rd_chk(tci_pkg::OFS_EN_CLR, 32'h0000_0083, "enables");
      wb_write(tci_pkg::OFS_EN_CLR, 32'h0000_0001);
      rd_chk(tci_pkg::OFS_MASKED, 32'h0000_0080, "masked");
      rd_chk(tci_pkg::OFS_VECTOR, 32'h0080_0000, "vector");
      wb_write(tci_pkg::OFS_EN_CLR, 32'h0000_0000);
      rd_chk(tci_pkg::OFS_EN_SET, 32'h0000_0082, "enables");
      wb_write(tci_pkg::OFS_RAW, 32'hffff_ffff);
      wb_write(tci_pkg::OFS_MASKED, 32'hffff_ffff);
      rd_chk(tci_pkg::OFS_RAW, 32'h0000_00a5, "raw");
      rd_chk(8'h40, 32'h0000_0000, "unmapped");
      // Channel 7 drops while enabled; the request must follow it down.
      tx_pend <= 8'h25;
      rd_chk(tci_pkg::OFS_RAW, 32'h0000_0025, "raw");
      rd_chk(tci_pkg::OFS_MASKED, 32'h0000_0000, "masked");
      #1 flag_chk("tx_irq", 1'b0, tx_irq);
      // Event status, mask and level interrupt.
      rd_chk(tci_pkg::OFS_EVT_ST, 32'h0000_00a5, "events");
      #1 flag_chk("irq", 1'b0, irq);
      wb_write(tci_pkg::OFS_EVT_MSK, 32'h0000_0004);
      #1 flag_chk("irq", 1'b1, irq);
      wb_write(tci_pkg::OFS_EVT_ST, 32'h0000_0004);
      #1 flag_chk("irq", 1'b0, irq);
      rd_chk(tci_pkg::OFS_EVT_ST, 32'h0000_00a1, "events");
      // Freeze the block: a pending change must not reach the views.
      ce      <= 1'b0;
      tx_pend <= 8'h80;
      repeat (3) @(posedge clock);
      #1 flag_chk("tx_irq frozen", 1'b0, tx_irq);
      @(posedge clock);
      ce <= 1'b1;
      rd_chk(tci_pkg::OFS_RAW, 32'h0000_0080, "raw");
      #1 flag_chk("tx_irq", 1'b1, tx_irq);
      // A reset in mid-run must clear every enable again.
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      #1 flag_chk("tx_irq after reset", 1'b0, tx_irq);
      rd_chk(tci_pkg::OFS_EN_SET, 32'h0000_0000, "enables");
      finish_test();
   end
endmodule : tb

`default_nettype wire
